/* File: logic/txn_mapper_consts.vh */
// Purpose: Shared constants of the inbound transaction mapper
// Assumes: Included by bare name from the design files
// Notes: Definitions only, no logic
`ifndef TXN_MAPPER_CONSTS_VH
`define TXN_MAPPER_CONSTS_VH

// ----------------------------------------------------------------
// Guest operation and size codes
// ----------------------------------------------------------------
`define OP_READ 2'h0
`define OP_WRITE 2'h1
`define OP_CLEAR 2'h2
`define SZ_PART 2'h0
`define SZ_HALF 2'h1
`define SZ_FULL 2'h2

// ----------------------------------------------------------------
// Page type bits: low bit checked page, high bit hold enable
// ----------------------------------------------------------------
`define PG_CHECKED 0
`define PG_HOLD_EN 1

// ----------------------------------------------------------------
// System bus commands
// ----------------------------------------------------------------
`define CMD_NONE 3'h0
`define CMD_READ_SHARED_OR_EXCL 3'h1
`define CMD_READ_PRIVATE 3'h2
`define CMD_LINE_WRITEBACK 3'h3
`define CMD_HALF_STORE_INVAL 3'h4
`define CMD_FULL_STORE_INVAL 3'h5

// ----------------------------------------------------------------
// Inbound queue entry fields, offsets above the address
// ----------------------------------------------------------------
`define F_KIND 0
`define F_OP 1
`define F_SIZE 3
`define F_PAGE 5
`define F_CONN 7
`define F_ATOM 8
`define F_PFH 9
`define F_PFEN 10
`define F_REGRD 11
`define F_EXTRA 12
`define KIND_GUEST 1'b0
`define KIND_RETURN 1'b1

// Cache line of 32 bytes
`define LINE_LSB 5

// ----------------------------------------------------------------
// APB register map
// ----------------------------------------------------------------
`define REG_CTRL 12'h000
`define REG_STATUS 12'h004
`define REG_COUNT 12'h008
`define CTRL_MAP_EN 0
`define CTRL_PF_EN 1
`define CTRL_RESET 32'h0000_0003
`define ST_LOCK_BIT 8
`define ST_HOLD_BIT 9
`define ST_CNT_LSB 16

`endif

/* File: logic/sync2.v */
// Purpose: Two-stage synchroniser for a bus of pin levels
// Assumes: Each bit is a level, or stable around a toggle edge
// Notes: The first stage feeds only the second stage
`timescale 1ns/10ps
`default_nettype none

module sync2 #(
  parameter W = 1
) (
  input wire pclk,
  input wire presetn,
  input wire [W-1:0] d,
  output wire [W-1:0] q
);

  reg [W-1:0] meta_q;
  reg [W-1:0] sync_q;

  // ----------------------------------------------------------------
  // Two flops, constant reset
  // ----------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= {W{1'b0}};
      sync_q <= {W{1'b0}};
    end else begin
      meta_q <= d;
      sync_q <= meta_q;
    end
  end

  assign q = sync_q;

endmodule // sync2

`default_nettype wire

/* File: logic/io_to_system_txn_mapper.v */
// Purpose: Maps guest I/O bus transactions onto system bus sequences
// Assumes: Guest fields stable before each toggle of its strobe
// Notes: One command in flight; system bus handshake is valid/ready
`timescale 1ns/10ps
`default_nettype none
`include "txn_mapper_consts.vh"

// What this block does
// - Half and full reads without atomic go read_shared, prefetch-eligible
// - Any atomic read goes out as read_private
// - After atomic read: same-line write writes back, else release line
// - Atomic reads always return blocking
// - Atomic request suppresses any prefetch
// - Prefetch needs hint, eligible map case and page prefetch enable
// - Read-modify-write is read_private then line_writeback
// - Partial writes without atomic read-modify-write, writeback only after same-line atomic read
// - Half writes: store-invalidate unchecked, read-modify-write checked
// - Full writes without atomic: one full_line_store_invalidate
// - Atomic writes read-modify-write, read skipped after atomic read of the same line
// - Full writes maybe semaphore halves still one full_line_store_invalidate
// - Fetch_and_clear: four words read, first cleared, written back
// - Fetch_and_clear data always returns blocking
// - Memory hold only with atomic request and page hold enable
// - Atomic request pin inverted on entry to active high
// - Transaction info goes to inbound queue, data kept elsewhere
// - Entry kind bit: 0 guest transaction, 1 return or register read
// - Page low bit checked, page high bit enables memory hold
// - Read_shared is issued as read_shared_or_exclusive
// - Prefetch hint pin inverted on entry to active high
module io_to_system_txn_mapper #(
  parameter AW = 32,
  parameter QD = 4,
  parameter QAW = 2
) (
  input wire pclk,
  input wire presetn,
  input wire [31:0] paddr,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] pwdata,
  output wire pready,
  output reg [31:0] prdata,
  output wire pslverr,
  input wire guest_tgl,
  input wire [1:0] guest_op,
  input wire [1:0] guest_size,
  input wire [1:0] guest_page_type,
  input wire guest_connected,
  input wire atomic_req_n,
  input wire prefetch_hint_n,
  input wire tlb_prefetch_en,
  input wire [AW-1:0] guest_addr,
  input wire ret_tgl,
  input wire ret_is_reg_read,
  output wire iq_full,
  output wire sys_valid,
  input wire sys_ready,
  output reg [2:0] sys_cmd,
  output reg [AW-1:0] sys_addr,
  output reg global_memory_hold,
  output reg blocking_return,
  output reg clear_first_word,
  output reg prefetch_req,
  output reg line_release,
  output reg ret_fwd,
  output reg ret_fwd_reg_read
);

  localparam EW = AW + `F_EXTRA;
  localparam SW = AW + 13;
  localparam [4:0] S_IDLE = 5'h01;
  localparam [4:0] S_RD = 5'h02;
  localparam [4:0] S_WB = 5'h04;
  localparam [4:0] S_ST = 5'h08;
  localparam [4:0] S_REL = 5'h10;
  localparam [QAW:0] QD_CNT = QD;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  wire [SW-1:0] pin_raw;
  wire [SW-1:0] pin_s;

  assign pin_raw = {ret_is_reg_read, ret_tgl, tlb_prefetch_en,
    prefetch_hint_n, atomic_req_n, guest_connected, guest_page_type,
    guest_size, guest_op, guest_tgl, guest_addr};

  sync2 #(.W(SW)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .d(pin_raw),
    .q(pin_s)
  );

  wire g_tgl_s = pin_s[AW];
  wire r_tgl_s = pin_s[AW+11];
  // Inverted on entry to active high flags
  wire atomic_s = ~pin_s[AW+8];
  wire pf_hint_s = ~pin_s[AW+9];

  // ----------------------------------------------------------------
  // Strobe detection and pending capture
  // ----------------------------------------------------------------
  reg g_tgl_q;
  reg r_tgl_q;
  reg g_pend_q;
  reg r_pend_q;
  reg [EW-1:0] g_ent_q;
  reg r_reg_q;
  wire g_evt = g_tgl_s ^ g_tgl_q;
  wire r_evt = r_tgl_s ^ r_tgl_q;
  wire push_g;
  wire push_r;

  // Guest strobe wins a push slot; a return waits one cycle
  assign push_g = g_pend_q && !iq_full;
  assign push_r = r_pend_q && !push_g && !iq_full;

  // Pending flags: a new event beats the clear of the push
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      g_tgl_q <= 1'b0;
      r_tgl_q <= 1'b0;
      g_pend_q <= 1'b0;
      r_pend_q <= 1'b0;
      g_ent_q <= {EW{1'b0}};
      r_reg_q <= 1'b0;
    end else begin
      g_tgl_q <= g_tgl_s;
      r_tgl_q <= r_tgl_s;
      if (g_evt) begin
        g_pend_q <= 1'b1;
        g_ent_q <= {1'b0, tlb_pf_bit(pin_s[AW+10]), pf_hint_s, atomic_s,
          pin_s[AW+7], pin_s[AW+6:AW+5], pin_s[AW+4:AW+3],
          pin_s[AW+2:AW+1], `KIND_GUEST, pin_s[AW-1:0]};
      end else if (push_g) begin
        g_pend_q <= 1'b0;
      end
      if (r_evt) begin
        r_pend_q <= 1'b1;
        r_reg_q <= pin_s[AW+12];
      end else if (push_r) begin
        r_pend_q <= 1'b0;
      end
    end
  end

  // Field is already a plain bit; kept as a hook for masking
  function tlb_pf_bit;
    input b;
    begin
      tlb_pf_bit = b;
    end
  endfunction

  // ----------------------------------------------------------------
  // Inbound queue: transaction info only, data lives elsewhere
  // ----------------------------------------------------------------
  reg [EW:0] iq_mem [0:QD-1];
  reg [QAW-1:0] wr_ptr_q;
  reg [QAW-1:0] rd_ptr_q;
  reg [QAW:0] cnt_q;
  reg [4:0] state_q;
  reg [31:0] ctrl_q;
  wire pop;
  wire [EW:0] head = iq_mem[rd_ptr_q];
  wire [EW:0] push_ent = push_g ? {1'b0, g_ent_q} :
    {r_reg_q, {(EW-AW-1){1'b0}}, `KIND_RETURN, {AW{1'b0}}};

  assign iq_full = (cnt_q == QD_CNT);
  assign pop = (state_q == S_IDLE) && ctrl_q[`CTRL_MAP_EN] &&
    (cnt_q != {(QAW+1){1'b0}});

  // Queue storage, written by the guest side strobes
  always @(posedge pclk) begin
    if (push_g || push_r) begin
      iq_mem[wr_ptr_q] <= push_ent;
    end
  end

  // Pointers and occupancy
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_ptr_q <= {QAW{1'b0}};
      rd_ptr_q <= {QAW{1'b0}};
      cnt_q <= {(QAW+1){1'b0}};
    end else begin
      if (push_g || push_r) begin
        wr_ptr_q <= wr_ptr_q + {{(QAW-1){1'b0}}, 1'b1};
      end
      if (pop) begin
        rd_ptr_q <= rd_ptr_q + {{(QAW-1){1'b0}}, 1'b1};
      end
      cnt_q <= cnt_q + {{QAW{1'b0}}, (push_g || push_r)} -
        {{QAW{1'b0}}, pop};
    end
  end

  // ----------------------------------------------------------------
  // Transaction map
  // ----------------------------------------------------------------
  // Returns {read phase, read private, writeback, store phase}
  function [3:0] plan;
    input [1:0] op;
    input [1:0] size;
    input checked;
    input atomic;
    begin
      plan = 4'h0;
      case (op)
        `OP_READ: begin
          if (atomic)
            plan = 4'hC;
          else
            plan = 4'h8;
        end
        `OP_WRITE: begin
          if (atomic)
            plan = 4'hE;
          else if (size == `SZ_PART)
            plan = 4'hE;
          else if (size == `SZ_HALF && checked)
            plan = 4'hE;
          else
            plan = 4'h1;
        end
        `OP_CLEAR: plan = 4'hE;
        default: plan = 4'h0;
      endcase
    end
  endfunction

  wire [1:0] h_op = head[AW+`F_OP+1:AW+`F_OP];
  wire [1:0] h_size = head[AW+`F_SIZE+1:AW+`F_SIZE];
  wire [1:0] h_page = head[AW+`F_PAGE+1:AW+`F_PAGE];
  wire h_atom = head[AW+`F_ATOM];
  wire [3:0] h_plan = plan(h_op, h_size, h_page[`PG_CHECKED], h_atom);

  // ----------------------------------------------------------------
  // Working registers and the private line tracker
  // ----------------------------------------------------------------
  reg [4:0] state_d;
  reg [3:0] plan_q;
  reg [1:0] op_q;
  reg [1:0] size_q;
  reg atom_q;
  reg pf_want_q;
  reg lock_held_q;
  reg [AW-1:0] lock_addr_q;
  reg [31:0] issued_q;
  wire same_line = lock_held_q &&
    (head[AW-1:`LINE_LSB] == lock_addr_q[AW-1:`LINE_LSB]);
  wire head_is_wr = (h_op == `OP_WRITE);
  // Same-line write after an atomic read reuses the held line
  wire skip_rd = same_line && head_is_wr;
  wire do_release = lock_held_q && !skip_rd;
  wire fire = sys_valid && sys_ready;

  // Next state
  always @* begin
    state_d = state_q;
    case (state_q)
      S_IDLE: begin
        if (pop && !head[AW+`F_KIND]) begin
          if (do_release)
            state_d = S_REL;
          else if (h_plan[3] && !skip_rd)
            state_d = S_RD;
          else if (h_plan[1] || skip_rd)
            state_d = S_WB;
          else if (h_plan[0])
            state_d = S_ST;
          else
            state_d = S_IDLE;
        end
      end
      S_REL: begin
        if (plan_q[3])
          state_d = S_RD;
        else if (plan_q[1])
          state_d = S_WB;
        else
          state_d = S_ST;
      end
      S_RD: begin
        if (fire)
          state_d = plan_q[1] ? S_WB : S_IDLE;
      end
      S_WB: if (fire) state_d = S_IDLE;
      S_ST: if (fire) state_d = S_IDLE;
      default: state_d = S_IDLE;
    endcase
  end

  assign sys_valid = (state_q == S_RD) || (state_q == S_WB) ||
    (state_q == S_ST);

  // Command for the state being entered
  function [2:0] cmd_for;
    input [4:0] st;
    input [3:0] pl;
    input [1:0] sz;
    begin
      case (st)
        S_RD: cmd_for = pl[2] ? `CMD_READ_PRIVATE :
          `CMD_READ_SHARED_OR_EXCL;
        S_WB: cmd_for = `CMD_LINE_WRITEBACK;
        S_ST: cmd_for = (sz == `SZ_HALF) ? `CMD_HALF_STORE_INVAL :
          `CMD_FULL_STORE_INVAL;
        default: cmd_for = `CMD_NONE;
      endcase
    end
  endfunction

  // Sequencer and registered system bus outputs
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= S_IDLE;
      plan_q <= 4'h0;
      op_q <= `OP_READ;
      size_q <= `SZ_PART;
      atom_q <= 1'b0;
      pf_want_q <= 1'b0;
      lock_held_q <= 1'b0;
      lock_addr_q <= {AW{1'b0}};
      sys_cmd <= `CMD_NONE;
      sys_addr <= {AW{1'b0}};
      global_memory_hold <= 1'b0;
      blocking_return <= 1'b0;
      clear_first_word <= 1'b0;
      prefetch_req <= 1'b0;
      line_release <= 1'b0;
      ret_fwd <= 1'b0;
      ret_fwd_reg_read <= 1'b0;
      issued_q <= 32'h0000_0000;
    end else begin
      state_q <= state_d;
      prefetch_req <= 1'b0;
      line_release <= 1'b0;
      ret_fwd <= 1'b0;
      sys_cmd <= cmd_for(state_d, (state_q == S_IDLE) ?
        (h_plan | {3'h0, 1'b0}) : plan_q, (state_q == S_IDLE) ?
        h_size : size_q);
      if (pop && head[AW+`F_KIND]) begin
        // Return entries only pass through to the outbound side
        ret_fwd <= 1'b1;
        ret_fwd_reg_read <= head[EW];
      end
      if (pop && !head[AW+`F_KIND]) begin
        plan_q <= skip_rd ? {1'b0, h_plan[2:0]} : h_plan;
        op_q <= h_op;
        size_q <= h_size;
        atom_q <= h_atom;
        sys_addr <= head[AW-1:0];
        // Hold only for atomic request on a hold-enabled page
        global_memory_hold <= h_atom && h_page[`PG_HOLD_EN];
        // Atomic reads and fetch_and_clear always return blocking
        blocking_return <= (h_op != `OP_WRITE) && (head[AW+`F_CONN] ||
          h_atom || h_op == `OP_CLEAR);
        clear_first_word <= (h_op == `OP_CLEAR);
        // Map-eligible, hinted, page enabled and no atomic request
        pf_want_q <= (h_op == `OP_READ) && !h_atom &&
          (h_size != `SZ_PART) && head[AW+`F_PFH] &&
          head[AW+`F_PFEN] && ctrl_q[`CTRL_PF_EN];
        if (do_release) begin
          line_release <= 1'b1;
          lock_held_q <= 1'b0;
        end
        if (!h_plan[3] && (h_plan[1] || skip_rd) && !do_release)
          sys_cmd <= `CMD_LINE_WRITEBACK;
      end
      if (state_q == S_REL && !plan_q[3])
        sys_cmd <= plan_q[1] ? `CMD_LINE_WRITEBACK :
          cmd_for(S_ST, plan_q, size_q);
      if (state_q == S_RD && fire) begin
        issued_q <= issued_q + 32'h0000_0001;
        prefetch_req <= pf_want_q;
        // A lone atomic read keeps its line private
        if (op_q == `OP_READ && atom_q) begin
          lock_held_q <= 1'b1;
          lock_addr_q <= sys_addr;
        end
      end
      if ((state_q == S_WB || state_q == S_ST) && fire) begin
        issued_q <= issued_q + 32'h0000_0001;
        global_memory_hold <= 1'b0;
        if (state_q == S_WB)
          lock_held_q <= 1'b0;
      end
      if (state_q == S_RD && fire && !plan_q[1])
        global_memory_hold <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // APB slave, zero wait states
  // ----------------------------------------------------------------
  wire [11:0] reg_off = paddr[11:0];
  wire hit_ctrl = (reg_off == `REG_CTRL);
  wire hit_stat = (reg_off == `REG_STATUS);
  wire hit_cnt = (reg_off == `REG_COUNT);
  wire mapped = hit_ctrl || hit_stat || hit_cnt;
  wire apb_acc = psel && penable;
  wire [31:0] status_w = {{(16-QAW-1){1'b0}}, cnt_q, 6'h00,
    global_memory_hold, lock_held_q, 3'h0, state_q};

  assign pready = 1'b1;
  // Unmapped offsets answer with an error, nothing stored
  assign pslverr = apb_acc && !mapped;

  // Control register: map enable and global prefetch enable
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      ctrl_q <= `CTRL_RESET;
    else if (apb_acc && pwrite && hit_ctrl)
      ctrl_q <= {30'h0000_0000, pwdata[`CTRL_PF_EN],
        pwdata[`CTRL_MAP_EN]};
  end

  // Read data, registered in the setup cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (psel && !penable && !pwrite)
      prdata <= hit_ctrl ? ctrl_q : hit_stat ? status_w :
        hit_cnt ? issued_q : 32'h0000_0000;
  end

endmodule // io_to_system_txn_mapper

`default_nettype wire

/* File: tb/sys_mem_model.sv */
// Purpose: System memory bus responder for the transaction mapper
// Assumes: Request is a level held until accepted
// Notes: slow adds three cycles of stall to every request
`timescale 1ns/10ps
`default_nettype none

module sys_mem_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic sys_valid,
  input wire logic slow,
  output wire logic sys_ready
);
  logic [1:0] wait_q;
  logic [1:0] wait_d;

  // Ready only with a request, so an idle bus never shows a stale accept
  assign sys_ready = sys_valid && (!slow || wait_q == 2'h3);
  assign wait_d = (!sys_valid || sys_ready) ? 2'h0 : wait_q + 2'h1;

  // Stall counter restarts on every accept
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_q <= 2'h0;
    end else begin
      wait_q <= wait_d;
    end
  end
endmodule // sys_mem_model

`default_nettype wire

/* File: tb/txn_mapper_assertions.sv */
// Purpose: Port level checks of the transaction mapper
// Assumes: One clock domain, reset asynchronous active low
// Notes: Bound to every instance of the mapper
`timescale 1ns/10ps
`default_nettype none
`include "txn_mapper_consts.vh"

module txn_mapper_checker #(
  parameter AW = 32
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [31:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic sys_valid,
  input wire logic sys_ready,
  input wire logic [2:0] sys_cmd,
  input wire logic [AW-1:0] sys_addr,
  input wire logic global_memory_hold,
  input wire logic blocking_return,
  input wire logic clear_first_word,
  input wire logic prefetch_req,
  input wire logic line_release,
  input wire logic ret_fwd
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // ----------------------------------------------------------------
  // System bus handshake
  // ----------------------------------------------------------------
  sequence s_stall; sys_valid && !sys_ready; endsequence
  sequence s_accept; sys_valid && sys_ready; endsequence

  property p_valid_hold;
    s_stall |=> sys_valid && $stable(sys_cmd) && $stable(sys_addr);
  endproperty
  a_valid_hold: assert property (p_valid_hold)
    else $error("system request changed while stalled");
  property p_cmd_legal;
    sys_valid |-> sys_cmd >= `CMD_READ_SHARED_OR_EXCL
      && sys_cmd <= `CMD_FULL_STORE_INVAL;
  endproperty
  a_cmd_legal: assert property (p_cmd_legal)
    else $error("undefined system command issued");
  property p_hold_atomic;
    s_accept ##0 global_memory_hold |->
      sys_cmd == `CMD_READ_PRIVATE || sys_cmd == `CMD_LINE_WRITEBACK;
  endproperty
  a_hold_atomic: assert property (p_hold_atomic)
    else $error("memory hold on a non-atomic command");

  // ----------------------------------------------------------------
  // Side pulses and levels
  // ----------------------------------------------------------------
  property p_pf_shared;
    prefetch_req |-> !global_memory_hold && $past(sys_valid && sys_ready)
      && $past(sys_cmd) == `CMD_READ_SHARED_OR_EXCL ##1 !prefetch_req;
  endproperty
  a_pf_shared: assert property (p_pf_shared)
    else $error("prefetch outside a plain shared read");
  property p_rel_pulse;
    line_release |-> !sys_valid ##1 !line_release;
  endproperty
  a_rel_pulse: assert property (p_rel_pulse)
    else $error("line release overlaps a request");
  property p_clear_blk;
    clear_first_word |-> blocking_return;
  endproperty
  a_clear_blk: assert property (p_clear_blk)
    else $error("clear without a blocking return");
  property p_ret_pulse;
    ret_fwd |=> !ret_fwd;
  endproperty
  a_ret_pulse: assert property (p_ret_pulse)
    else $error("return forward longer than one cycle");
  property p_apb_resp;
    psel && penable |-> pready && (pslverr == !(paddr[11:0] inside
      {`REG_CTRL, `REG_STATUS, `REG_COUNT}));
  endproperty
  a_apb_resp: assert property (p_apb_resp)
    else $error("register access answered wrongly");
endmodule // txn_mapper_checker

bind io_to_system_txn_mapper txn_mapper_checker #(.AW(AW)) u_chk (
  .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
  .penable(penable), .pready(pready), .pslverr(pslverr),
  .sys_valid(sys_valid), .sys_ready(sys_ready), .sys_cmd(sys_cmd),
  .sys_addr(sys_addr), .global_memory_hold(global_memory_hold),
  .blocking_return(blocking_return), .clear_first_word(clear_first_word),
  .prefetch_req(prefetch_req), .line_release(line_release),
  .ret_fwd(ret_fwd));

`default_nettype wire

/* File: tb/test_io_to_system_txn_mapper.sv */
// Purpose: Directed test of the inbound transaction mapper
// Assumes: Partner answers the system bus, bench plays guests and APB
// Notes: Cases are packed vectors to keep the table short
`timescale 1ns/10ps
`default_nettype none
`include "txn_mapper_consts.vh"

module test_io_to_system_txn_mapper;
  reg pclk = 1'b0;
  reg presetn = 1'b0;
  reg psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  reg [31:0] paddr = 32'h0, pwdata = 32'h0, guest_addr = 32'h0;
  reg guest_tgl = 1'b0, guest_connected = 1'b0;
  reg [1:0] guest_op = 2'h0, guest_size = 2'h0, guest_page_type = 2'h0;
  reg atomic_req_n = 1'b1, prefetch_hint_n = 1'b1, tlb_prefetch_en = 1'b0;
  reg ret_tgl = 1'b0, ret_is_reg_read = 1'b0, slow = 1'b0;
  wire pready, pslverr, iq_full, sys_valid, sys_ready, global_memory_hold;
  wire blocking_return, clear_first_word, prefetch_req, line_release;
  wire ret_fwd, ret_fwd_reg_read;
  wire [31:0] prdata, sys_addr;
  wire [2:0] sys_cmd;
  integer fails = 0, num_checks = 0, cyc = 0, acc_n = 0, tot = 0;
  integer pf_n = 0, rel_n = 0, ret_n = 0, w = 0;
  reg [2:0] acc_c [0:3];
  reg acc_h = 1'b0, acc_b = 1'b0, acc_k = 1'b0, ret_rr = 1'b0, rerr = 1'b0;
  reg [31:0] rdata = 32'h0, acc_a = 32'h0;

  io_to_system_txn_mapper i_dut (.pclk(pclk), .presetn(presetn),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .guest_tgl(guest_tgl), .guest_op(guest_op), .guest_size(guest_size),
    .guest_page_type(guest_page_type), .guest_connected(guest_connected),
    .atomic_req_n(atomic_req_n), .prefetch_hint_n(prefetch_hint_n),
    .tlb_prefetch_en(tlb_prefetch_en), .guest_addr(guest_addr),
    .ret_tgl(ret_tgl), .ret_is_reg_read(ret_is_reg_read),
    .iq_full(iq_full), .sys_valid(sys_valid), .sys_ready(sys_ready),
    .sys_cmd(sys_cmd), .sys_addr(sys_addr),
    .global_memory_hold(global_memory_hold),
    .blocking_return(blocking_return), .clear_first_word(clear_first_word),
    .prefetch_req(prefetch_req), .line_release(line_release),
    .ret_fwd(ret_fwd), .ret_fwd_reg_read(ret_fwd_reg_read));
  sys_mem_model i_mem (.pclk(pclk), .presetn(presetn),
    .sys_valid(sys_valid), .slow(slow), .sys_ready(sys_ready));

  // 200 MHz clock
  always #2.5 pclk = ~pclk;

  // Records accepted commands and side pulses of the current case
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (sys_valid && sys_ready) begin
      acc_c[acc_n[1:0]] <= sys_cmd;
      if (acc_n == 0) begin
        acc_b <= blocking_return;
        acc_k <= clear_first_word;
        acc_a <= sys_addr;
      end
      acc_h <= acc_h | global_memory_hold;
      acc_n <= acc_n + 1;
      tot <= tot + 1;
    end
    if (prefetch_req) pf_n <= pf_n + 1;
    if (line_release) rel_n <= rel_n + 1;
    if (ret_fwd) begin
      ret_n <= ret_n + 1;
      ret_rr <= ret_fwd_reg_read;
    end
  end

  // Hang guard, far above the expected run length
  always @(posedge pclk) begin
    if (cyc == 4000) begin
      fails = fails + 1;
      test_done;
    end
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task check(input [31:0] got, input [31:0] exp);
    begin
      num_checks = num_checks + 1;
      if (got !== exp) begin
        fails = fails + 1;
        $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask

  // One APB transfer; the idle edge first avoids a double drive
  task apb(input wr, input [31:0] a, input [31:0] d);
    begin
      @(posedge pclk);
      psel <= 1'b1;
      paddr <= a;
      pwrite <= wr;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      w = 0;
      @(posedge pclk);
      while (pready !== 1'b1 && w < 20) begin
        @(posedge pclk);
        w = w + 1;
      end
      rdata = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask

  // f: op, size, page, atomic, connected; p: hint, page prefetch
  // e: count, second and first command; x: prefetch, hold, release
  task guest(input [7:0] f, input [1:0] p, input [15:0] a,
             input [7:0] e, input [2:0] x);
    begin
      acc_n = 0;
      acc_h = 1'b0;
      pf_n = 0;
      rel_n = 0;
      slow <= ~slow;
      guest_op <= f[7:6];
      guest_size <= f[5:4];
      guest_page_type <= f[3:2];
      atomic_req_n <= ~f[1];
      guest_connected <= f[0];
      prefetch_hint_n <= ~p[1];
      tlb_prefetch_en <= p[0];
      guest_addr <= {16'h0, a};
      repeat (3) @(posedge pclk);
      guest_tgl <= ~guest_tgl;
      w = 0;
      while (acc_n < e[7:6] && w < 80) begin
        @(posedge pclk);
        w = w + 1;
      end
      // Room for a late prefetch pulse or a stray extra command
      repeat (8) @(posedge pclk);
      check(acc_n, e[7:6]);
      check(acc_c[0], e[2:0]);
      if (e[7:6] == 2'h2) check(acc_c[1], e[5:3]);
      check(pf_n, x[2]);
      check(acc_h, x[1]);
      check(rel_n, x[0]);
      if (f[7:6] != `OP_WRITE) check(acc_b, f[1] | f[0] | f[7]);
      check(acc_k, f[7]);
      check(acc_a, {16'h0, a});
      $display("guest case %h done", f);
    end
  endtask

  task test_done;
    begin
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0)
        $display("Test passed");
      else
        $display("Test failed");
      $finish;
    end
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, {20'h0, `REG_CTRL}, 32'h0);
    check(rdata, `CTRL_RESET);
    apb(1'b0, 32'h0000_0010, 32'h0);
    check(rerr, 1'b1);
    apb(1'b1, {20'h0, `REG_CTRL}, 32'hFFFF_FFFD);
    apb(1'b0, {20'h0, `REG_CTRL}, 32'h0);
    check(rdata, 32'h0000_0001);
    apb(1'b1, {20'h0, `REG_CTRL}, `CTRL_RESET);
    $display("register case done");
    guest(8'h01, 2'h3, 16'h0100, 8'h41, 3'h0);
    guest(8'h14, 2'h3, 16'h0200, 8'h41, 3'h4);
    guest(8'h21, 2'h2, 16'h0220, 8'h41, 3'h0);
    guest(8'h2A, 2'h3, 16'h0300, 8'h42, 3'h2);
    guest(8'h01, 2'h0, 16'h0400, 8'h41, 3'h1);
    guest(8'h40, 2'h0, 16'h0500, 8'h9A, 3'h0);
    guest(8'h50, 2'h0, 16'h0520, 8'h44, 3'h0);
    guest(8'h54, 2'h0, 16'h0540, 8'h9A, 3'h0);
    guest(8'h6C, 2'h0, 16'h0560, 8'h45, 3'h0);
    guest(8'h66, 2'h0, 16'h0580, 8'h9A, 3'h0);
    guest(8'h90, 2'h0, 16'h0600, 8'h9A, 3'h0);
    guest(8'h0F, 2'h3, 16'h0700, 8'h42, 3'h2);
    guest(8'h4F, 2'h0, 16'h0704, 8'h43, 3'h2);
    ret_is_reg_read <= 1'b1;
    ret_n = 0;
    @(posedge pclk);
    ret_tgl <= ~ret_tgl;
    w = 0;
    while (ret_n == 0 && w < 20) begin
      @(posedge pclk);
      w = w + 1;
    end
    check(ret_n, 32'h1);
    check(ret_rr, 1'b1);
    check(iq_full, 1'b0);
    $display("return case done");
    apb(1'b0, {20'h0, `REG_COUNT}, 32'h0);
    check(rdata, tot);
    test_done;
  end
endmodule // test_io_to_system_txn_mapper

`default_nettype wire
